//--- src/ams_pkg.sv
// Constants shared by the analog front end multiplexer sequencer.
// Assumes an 8-bit configuration byte bus and a 3-bit data RAM address.
package ams_pkg;

  // ==========================================================
  // Register map (byte addresses on the configuration port)
  localparam logic [15:0] ADDR_EQUATION_CONFIG   = 16'h2000;
  localparam logic [15:0] ADDR_MUX_DIV_CHOP_CFG  = 16'h2002;
  localparam logic [15:0] ADDR_FILTER_ALT_CONFIG = 16'h2005;
  localparam logic [15:0] ADDR_SEQ_STATUS        = 16'h2008;

  // ==========================================================
  // Field positions
  localparam int EQU_MSB  = 7;
  localparam int EQU_LSB  = 5;
  localparam int DIV_MSB  = 7;
  localparam int DIV_LSB  = 6;
  localparam int CHOP_MSB = 5;
  localparam int CHOP_LSB = 4;
  localparam int FLEN_BIT = 4;
  localparam int ALT_BIT  = 2;

  // Reset values of the configuration bytes
  localparam logic [7:0] EQUATION_RESET  = 8'h00;
  localparam logic [7:0] MUXDIV_RESET    = 8'h40;
  localparam logic [7:0] FILTALT_RESET   = 8'h00;

  // ==========================================================
  // Field encodings
  localparam logic [2:0] EQU_TWO_WIRE   = 3'h0;
  localparam logic [2:0] EQU_THREE_WIRE = 3'h1;
  localparam logic [1:0] DIV_FORBIDDEN  = 2'h0;
  localparam logic [1:0] DIV_FOUR       = 2'h1;
  localparam logic [1:0] DIV_THREE      = 2'h2;
  localparam logic [1:0] DIV_TWO        = 2'h3;
  localparam logic [1:0] CHOP_REGULAR   = 2'h1;
  localparam logic [1:0] CHOP_INVERTED  = 2'h2;

  // Channel codes on the multiplexer select output
  localparam logic [2:0] CHAN_NONE = 3'h0;
  localparam logic [2:0] CHAN_IA   = 3'h1;
  localparam logic [2:0] CHAN_VA   = 3'h2;
  localparam logic [2:0] CHAN_IB   = 3'h3;
  localparam logic [2:0] CHAN_TEMP = 3'h4;

  // Data RAM words for raw samples
  localparam logic [2:0] RAM_IA   = 3'h0;
  localparam logic [2:0] RAM_VA   = 3'h1;
  localparam logic [2:0] RAM_IB   = 3'h2;
  localparam logic [2:0] RAM_TEMP = 3'h6;

  // ==========================================================
  // Timing in low-frequency clock states
  localparam logic [3:0] PASS_F0_D4 = 4'h9;
  localparam logic [3:0] PASS_F0_D3 = 4'h7;
  localparam logic [3:0] PASS_F0_D2 = 4'h5;
  localparam logic [3:0] PASS_F1_D4 = 4'hD;
  localparam logic [3:0] PASS_F1_D3 = 4'hA;
  localparam logic [3:0] PASS_F1_D2 = 4'h7;
  localparam logic [1:0] CONV_F0    = 2'h2;
  localparam logic [1:0] CONV_F1    = 2'h3;
  localparam int         SAMPLE_W   = 22;

  // Sequencer phases
  typedef enum logic [1:0] {PH_SETTLE, PH_CONV, PH_IDLE} ams_phase_e;

endpackage : ams_pkg

//--- src/ams_sequencer.sv
// Multiplexer sequencer of the analog front end: channel stepping,
// conversion timing, chopper polarity and compute engine pass launch.
// Assumes clk is the 32768 Hz low-frequency clock and that the filter
// result and configuration port come from logic on that same clock.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns

// Contract
// - Normal cycle: IA, VA, IB, state 3 unused
// - Alternate: TEMP, VA, IB only for 001
// - Equation, divider, alternate request fields govern
// - Divider 01/10/11 give four/three/two states
// - Pass length 9/7/5 or 13/10/7 states
// - Request edge gives one alternate cycle next; an edge in the cycle's last clock gets the cycle after
// - Runs on slow clock, launches code pass
// - Drives filter start and chopper polarity
// - Filter length selects 21 or 22 bits
// - Conversion lasts two or three clocks
// - Sequencer alone starts every conversion
// - Filter result written to channel's word
// - Words IA 0, VA 1, IB 2, TEMP 6
// - Chopper field: regular, inverted or toggling
// - Toggle polarity only at cycle boundary
module ams_sequencer
(
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Configuration port
  input  wire logic [15:0]                  reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [7:0]                   reg_rdata,
  // Converter and filter
  output logic      [2:0]                   mux_select,
  output logic                              filter_start,
  output logic                              filter_length_select,
  output logic                              chop_polarity_select,
  input  wire logic [ams_pkg::SAMPLE_W-1:0] filter_data,
  // Compute engine
  output logic                              ce_start,
  output logic                              ram_we,
  output logic      [2:0]                   ram_addr,
  output logic      [ams_pkg::SAMPLE_W-1:0] ram_wdata
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0]                   equ_cfg;
    logic [7:0]                   div_cfg;
    logic [7:0]                   alt_cfg;
    logic [7:0]                   rdata;
    logic                         alt_prev;
    logic                         alt_pend;
    logic                         alt_act;
    logic [2:0]                   equ_act;
    logic [1:0]                   div_act;
    logic                         flen_act;
    logic                         chop;
    logic [3:0]                   cnt;
    logic [1:0]                   sub;
    logic [1:0]                   mstate;
    ams_pkg::ams_phase_e          phase;
    logic [2:0]                   sel;
    logic                         fstart;
    logic                         cestart;
    logic                         we;
    logic [2:0]                   waddr;
    logic [ams_pkg::SAMPLE_W-1:0] wdata;
  } ams_state_s;

  ams_state_s s_q;
  ams_state_s s_d;

  // ==========================================================
  // Lookup functions
  function automatic logic [3:0] pass_len(input logic [1:0] div,
                                          input logic       flen);
    unique case (div)
      ams_pkg::DIV_THREE:
        pass_len = flen ? ams_pkg::PASS_F1_D3 : ams_pkg::PASS_F0_D3;
      ams_pkg::DIV_TWO:
        pass_len = flen ? ams_pkg::PASS_F1_D2 : ams_pkg::PASS_F0_D2;
      default:
        pass_len = flen ? ams_pkg::PASS_F1_D4 : ams_pkg::PASS_F0_D4;
    endcase
  endfunction : pass_len

  function automatic logic [1:0] last_state(input logic [1:0] div);
    unique case (div)
      ams_pkg::DIV_THREE: last_state = 2'h2;
      ams_pkg::DIV_TWO:   last_state = 2'h1;
      default:            last_state = 2'h3;
    endcase
  endfunction : last_state

  function automatic logic [2:0] chan_of(input logic       alt,
                                         input logic [2:0] equation_config,
                                         input logic [1:0] st);
    chan_of = ams_pkg::CHAN_NONE;
    if (!alt)
    begin
      unique case (st)
        2'h0:    chan_of = ams_pkg::CHAN_IA;
        2'h1:    chan_of = ams_pkg::CHAN_VA;
        2'h2:    chan_of = ams_pkg::CHAN_IB;
        default: chan_of = ams_pkg::CHAN_NONE;
      endcase
    end
    else
    begin
      unique case (st)
        2'h0:    chan_of = ams_pkg::CHAN_TEMP;
        2'h1:    chan_of = ams_pkg::CHAN_VA;
        2'h2:    chan_of = (equation_config == ams_pkg::EQU_THREE_WIRE) ?
                           ams_pkg::CHAN_IB : ams_pkg::CHAN_NONE;
        default: chan_of = ams_pkg::CHAN_NONE;
      endcase
    end
  endfunction : chan_of

  function automatic logic [2:0] word_of(input logic [2:0] ch);
    unique case (ch)
      ams_pkg::CHAN_VA:   word_of = ams_pkg::RAM_VA;
      ams_pkg::CHAN_IB:   word_of = ams_pkg::RAM_IB;
      ams_pkg::CHAN_TEMP: word_of = ams_pkg::RAM_TEMP;
      default:            word_of = ams_pkg::RAM_IA;
    endcase
  endfunction : word_of

  // ==========================================================
  // Derived terms of the present state
  logic [1:0] conv_last;
  logic       alt_edge;
  logic       at_end;
  assign conv_last = (s_q.flen_act ? ams_pkg::CONV_F1 : ams_pkg::CONV_F0)
                     - 2'h1;
  // a one-cycle pulse still leaves an edge
  assign alt_edge  = s_q.alt_cfg[ams_pkg::ALT_BIT] & ~s_q.alt_prev;
  assign at_end    = s_q.cnt == pass_len(s_q.div_act, s_q.flen_act) - 4'h1;

  // ==========================================================
  // Next state
  always_comb
  begin
    s_d         = s_q;
    s_d.fstart  = 1'b0;
    s_d.cestart = 1'b0;
    s_d.rdata   = 8'h00;
    s_d.alt_prev = s_q.alt_cfg[ams_pkg::ALT_BIT];
    if (reg_wr)
    begin
      unique case (reg_addr)
        ams_pkg::ADDR_EQUATION_CONFIG:   s_d.equ_cfg = reg_wdata;
        ams_pkg::ADDR_MUX_DIV_CHOP_CFG:  s_d.div_cfg = reg_wdata;
        ams_pkg::ADDR_FILTER_ALT_CONFIG: s_d.alt_cfg = reg_wdata;
        default:                         s_d.equ_cfg = s_q.equ_cfg;
      endcase
    end
    // Reads answer one cycle later; unmapped reads give zero
    if (reg_rd)
    begin
      unique case (reg_addr)
        ams_pkg::ADDR_EQUATION_CONFIG:   s_d.rdata = s_q.equ_cfg;
        ams_pkg::ADDR_MUX_DIV_CHOP_CFG:  s_d.rdata = s_q.div_cfg;
        ams_pkg::ADDR_FILTER_ALT_CONFIG: s_d.rdata = s_q.alt_cfg;
        ams_pkg::ADDR_SEQ_STATUS:
          s_d.rdata = {s_q.alt_act, s_q.alt_pend, s_q.chop, s_q.flen_act,
                       s_q.div_act, s_q.mstate};
        default:                         s_d.rdata = 8'h00;
      endcase
    end

    // remember request; a new edge beats the clear
    if (alt_edge)
      s_d.alt_pend = 1'b1;
    // store result; the last state's conversion ends on the boundary
    s_d.we    = s_q.phase == ams_pkg::PH_CONV && s_q.sub == conv_last
                && s_q.sel != ams_pkg::CHAN_NONE;
    s_d.waddr = word_of(s_q.sel);
    s_d.wdata = filter_data;
    if (at_end)
    begin
      // Cycle boundary: settings only take effect here
      s_d.cnt     = 4'h0;
      s_d.phase   = ams_pkg::PH_SETTLE;
      s_d.sel     = ams_pkg::CHAN_NONE;
      s_d.equ_act = s_q.equ_cfg[ams_pkg::EQU_MSB:ams_pkg::EQU_LSB];
      s_d.flen_act = s_q.alt_cfg[ams_pkg::FLEN_BIT];
      // forbidden divider keeps the last valid one
      if (s_q.div_cfg[ams_pkg::DIV_MSB:ams_pkg::DIV_LSB]
          != ams_pkg::DIV_FORBIDDEN)
        s_d.div_act = s_q.div_cfg[ams_pkg::DIV_MSB:ams_pkg::DIV_LSB];
      // exactly one alternate cycle per request
      s_d.alt_act  = s_q.alt_pend;
      s_d.alt_pend = alt_edge;
      unique case (s_q.div_cfg[ams_pkg::CHOP_MSB:ams_pkg::CHOP_LSB])
        ams_pkg::CHOP_REGULAR:  s_d.chop = 1'b0;
        ams_pkg::CHOP_INVERTED: s_d.chop = 1'b1;
        default:                s_d.chop = ~s_q.chop;
      endcase
    end
    else
    begin
      s_d.cnt = s_q.cnt + 4'h1;
      unique case (s_q.phase)
        ams_pkg::PH_SETTLE:
        begin
          s_d.phase  = ams_pkg::PH_CONV;
          s_d.mstate = 2'h0;
          s_d.sub    = 2'h0;
          // code pass starts with mux state 0
          s_d.cestart = 1'b1;
        end
        ams_pkg::PH_CONV:
        begin
          if (s_q.sub == conv_last)
          begin
            s_d.sub   = 2'h0;
            if (s_q.mstate == last_state(s_q.div_act))
              s_d.phase = ams_pkg::PH_IDLE;
            else
              s_d.mstate = s_q.mstate + 2'h1;
          end
          else
            s_d.sub = s_q.sub + 2'h1;
        end
        default:
          s_d.phase = ams_pkg::PH_IDLE;
      endcase
      if (s_d.phase == ams_pkg::PH_CONV)
      begin
        s_d.sel = chan_of(s_q.alt_act, s_q.equ_act, s_d.mstate);
        // one start per state with a channel, spaced by conversion
        s_d.fstart = s_d.sub == 2'h0 && s_d.sel != ams_pkg::CHAN_NONE;
      end
      else
        s_d.sel = ams_pkg::CHAN_NONE;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q          <= '0;
      s_q.equ_cfg  <= ams_pkg::EQUATION_RESET;
      s_q.div_cfg  <= ams_pkg::MUXDIV_RESET;
      s_q.alt_cfg  <= ams_pkg::FILTALT_RESET;
      s_q.div_act  <= ams_pkg::DIV_FOUR;
      s_q.phase    <= ams_pkg::PH_SETTLE;
    end
    else
      s_q <= s_d;
  end

  // Outputs straight from flip-flops
  assign reg_rdata            = s_q.rdata;
  assign mux_select           = s_q.sel;
  assign filter_start         = s_q.fstart;
  assign chop_polarity_select = s_q.chop;
  assign filter_length_select = s_q.flen_act;
  assign ce_start             = s_q.cestart;
  assign ram_we               = s_q.we;
  assign ram_addr             = s_q.waddr;
  assign ram_wdata            = s_q.wdata;

  // ==========================================================
  // Checks
  logic [3:0] gap_q;
  logic [3:0] len_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      gap_q <= 4'h0;
      len_q <= 4'h0;
    end
    else
    begin
      gap_q <= ce_start ? 4'h1 : gap_q + 4'h1;
      if (ce_start)
        len_q <= pass_len(s_q.div_act, s_q.flen_act);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_pass_length: assert property (
    ce_start && len_q != 4'h0 |-> gap_q == len_q)
    else $error("code pass spacing wrong");
  chk_conv_short: assert property (
    ram_we && !$past(s_q.flen_act) |-> $past(filter_start, 2))
    else $error("short conversion not two cycles");
  chk_conv_long: assert property (
    ram_we && $past(s_q.flen_act) |-> $past(filter_start, 3))
    else $error("long conversion not three cycles");
  chk_normal_order: assert property (
    ce_start && !s_q.alt_act |-> mux_select == ams_pkg::CHAN_IA)
    else $error("normal cycle does not open with IA");
  chk_alt_temp: assert property (
    mux_select == ams_pkg::CHAN_TEMP |-> s_q.alt_act && s_q.mstate == 2'h0)
    else $error("temperature outside alternate state 0");
  chk_temp_word: assert property (
    ram_we && ram_addr == ams_pkg::RAM_TEMP |-> $past(s_q.alt_act))
    else $error("temperature word written in normal cycle");
  chk_chop_boundary: assert property (
    $changed(chop_polarity_select) |-> s_q.cnt == 4'h0)
    else $error("chopper moved inside a cycle");
  chk_alt_single: assert property (
    at_end && s_q.alt_pend && !alt_edge |=> s_q.alt_act && !s_q.alt_pend)
    else $error("pending request not served once");
  chk_div_valid: assert property (
    s_q.div_act != ams_pkg::DIV_FORBIDDEN)
    else $error("forbidden divider in use");

  cov_alt_cycle: cover property (ce_start && s_q.alt_act);
  cov_three_state: cover property (ce_start && s_q.div_act == 2'h2);
  cov_chop_toggle: cover property ($changed(chop_polarity_select));
endmodule : ams_sequencer

//--- verif/ams_ram_model.sv
// Data RAM of the compute engine and source of filter results.
// Assumes one write per finished conversion, all on clk.
`timescale 1ns/1ns
module ams_ram_model
(
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Write port from the sequencer
  input  wire logic                         ram_we,
  input  wire logic [2:0]                   ram_addr,
  input  wire logic [ams_pkg::SAMPLE_W-1:0] ram_wdata,
  // Filter result
  output logic      [ams_pkg::SAMPLE_W-1:0] filter_data
);
  // ==========================================================
  // Storage
  logic [ams_pkg::SAMPLE_W-1:0] mem_q [8];

  // New result every cycle, so a stale capture never matches
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      filter_data <= 22'h2A5A5A;
    else
      filter_data <= {filter_data[20:0], ~filter_data[21]} + 22'h000123;
  end

  always_ff @(posedge clk)
  begin
    if (ram_we)
      mem_q[ram_addr] <= ram_wdata;
  end
endmodule : ams_ram_model

//--- verif/tb_ams_sequencer.sv
// Self-checking bench of the multiplexer sequencer.
// Assumes registered outputs; the monitor sees them one edge late.
`timescale 1ns/1ns
module tb_ams_sequencer;
  // ==========================================================
  // Signals
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic [2:0]  mux_select, ram_addr;
  logic        filter_start, filter_length_select, chop_polarity_select;
  logic        ce_start, ram_we, cs_chop, cyc_chop, c1, chop_prev;
  logic [21:0] filter_data, ram_wdata, fd_prev;
  logic [8:0]  seq, cyc_seq;
  logic [2:0]  chq [$];
  int          errors = 0, check_count = 0;
  int          cnt, lfs, gap, n_cyc = 0, cyc_len, cyc_gap;
  typedef struct packed
  {logic [1:0] div; logic flen; logic [1:0] chop; logic [3:0] n;} ams_row_s;
  ams_row_s    rows [6] = '{'{2'h1, 1'b0, 2'h0, 4'h9},
    '{2'h2, 1'b0, 2'h1, 4'h7}, '{2'h3, 1'b0, 2'h2, 4'h5},
    '{2'h1, 1'b1, 2'h3, 4'hD}, '{2'h2, 1'b1, 2'h0, 4'hA},
    '{2'h3, 1'b1, 2'h1, 4'h7}};

  // ==========================================================
  // Design and partner
  ams_sequencer dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mux_select(mux_select),
    .filter_start(filter_start), .filter_length_select(filter_length_select),
    .chop_polarity_select(chop_polarity_select), .filter_data(filter_data),
    .ce_start(ce_start), .ram_we(ram_we), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata));
  ams_ram_model ram (.clk(clk), .rst(rst), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .filter_data(filter_data));

  // Clock, 10 ns period
  always #5 clk = ~clk;

  // ==========================================================
  // Tasks
  task automatic end_of_test;
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    check(24'(reg_rdata), 24'(exp));
  endtask : rd

  // Bounded wait for the next cycle snapshot
  task automatic next_cyc;
    int n0;
    n0 = n_cyc;
    for (int i = 0; i < 40 && n_cyc == n0; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (n_cyc == n0)
    begin
      errors++;
      end_of_test;
    end
  endtask : next_cyc

  function automatic logic [8:0] exp_seq(input logic alt, input logic eq3,
                                         input logic [1:0] div);
    logic [8:0] s;
    s = {3'h0, alt ? ams_pkg::CHAN_TEMP : ams_pkg::CHAN_IA, ams_pkg::CHAN_VA};
    if (div != ams_pkg::DIV_TWO && (!alt || eq3))
      s = {s[5:0], ams_pkg::CHAN_IB};
    return s;
  endfunction : exp_seq

  // ==========================================================
  // Monitor: one snapshot per multiplexer cycle
  always @(posedge clk)
  begin
    if (rst)
    begin
      cnt = 0;
      lfs = 0;
      seq = 9'h000;
      cs_chop = 1'b0;
      chq = {};
    end
    else
    begin
      if (ram_we === 1'b1)
      begin
        c1 = (chq.size() > 0);
        ram_wdata_chk(c1 ? chq.pop_front() : 3'h0);
      end
      if (ce_start === 1'b1)
      begin
        cyc_len = cnt;
        cyc_seq = seq;
        cyc_gap = gap;
        cyc_chop = cs_chop;
        cs_chop = chop_polarity_select;
        seq = 9'h000;
        cnt = 0;
        lfs = 0;
        n_cyc++;
      end
      if (filter_start === 1'b1)
      begin
        seq = {seq[5:0], mux_select};
        gap = cnt - lfs;
        lfs = cnt;
        chq.push_back(mux_select);
        check(24'(chop_polarity_select), 24'(cs_chop));
      end
      cnt++;
      fd_prev = filter_data;
    end
  end

  task automatic ram_wdata_chk(input logic [2:0] ch);
    check(24'(ram_addr), 24'(ch == ams_pkg::CHAN_TEMP ? ams_pkg::RAM_TEMP
                             : ch - 3'h1));
    check(24'(ram_wdata), 24'(fd_prev));
  endtask : ram_wdata_chk

  // Watchdog, far beyond the few hundred cycles of the run
  initial
  begin
    #200000;
    errors++;
    end_of_test;
  end

  // ==========================================================
  // Tests
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // row 4 is the preferred setting
    foreach (rows[i])
    begin
      wr(ams_pkg::ADDR_MUX_DIV_CHOP_CFG, {rows[i].div, rows[i].chop, 4'h0});
      wr(ams_pkg::ADDR_FILTER_ALT_CONFIG, {3'h0, rows[i].flen, 4'h0});
      rd(ams_pkg::ADDR_MUX_DIV_CHOP_CFG, {rows[i].div, rows[i].chop, 4'h0});
      next_cyc;
      next_cyc;
      chop_prev = cyc_chop;
      next_cyc;
      check(24'(cyc_len), 24'(rows[i].n));
      check(24'(cyc_seq), 24'(exp_seq(1'b0, 1'b0, rows[i].div)));
      check(24'(cyc_gap), rows[i].flen ? 24'h3 : 24'h2);
      check(24'(filter_length_select), 24'(rows[i].flen));
      if (rows[i].chop == ams_pkg::CHOP_REGULAR
          || rows[i].chop == ams_pkg::CHOP_INVERTED)
        check(24'(cyc_chop), 24'(rows[i].chop[1]));
      else
        check(24'(cyc_chop ^ chop_prev), 24'h1);
    end
    wr(ams_pkg::ADDR_MUX_DIV_CHOP_CFG, 8'h50);
    wr(ams_pkg::ADDR_FILTER_ALT_CONFIG, 8'h00);
    for (int e = 0; e < 2; e++)
    begin
      wr(ams_pkg::ADDR_EQUATION_CONFIG, {3'(e), 5'h00});
      next_cyc;
      next_cyc;
      wr(ams_pkg::ADDR_FILTER_ALT_CONFIG, 8'h04);
      wr(ams_pkg::ADDR_FILTER_ALT_CONFIG, 8'h00);
      next_cyc;
      next_cyc;
      check(24'(cyc_seq), 24'(exp_seq(1'b1, e[0], 2'h1)));
      next_cyc;
      check(24'(cyc_seq), 24'(exp_seq(1'b0, e[0], 2'h1)));
    end
    wr(ams_pkg::ADDR_MUX_DIV_CHOP_CFG, 8'hD0);
    next_cyc;
    next_cyc;
    wr(ams_pkg::ADDR_MUX_DIV_CHOP_CFG, 8'h10);
    next_cyc;
    next_cyc;
    next_cyc;
    check(24'(cyc_len), 24'h5);
    check(24'(cyc_seq), 24'(exp_seq(1'b0, 1'b0, 2'h3)));
    wr(16'h2001, 8'hFF);
    rd(16'h2001, 8'h00);
    // Reset in mid-run, then the first pass launch
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(24'({ce_start, filter_start, ram_we, mux_select}), 24'h0);
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check(24'({ce_start, filter_start}), 24'h3);
    rd(ams_pkg::ADDR_SEQ_STATUS, 8'h04);
    rd(ams_pkg::ADDR_EQUATION_CONFIG, 8'h00);
    rd(ams_pkg::ADDR_MUX_DIV_CHOP_CFG, 8'h40);
    rd(ams_pkg::ADDR_FILTER_ALT_CONFIG, 8'h00);
    end_of_test;
  end
endmodule : tb_ams_sequencer
